// ### rtl/emb_evbuf.sv
// Flip-flop event buffer with read at an offset from the oldest record.
module emb_evbuf
  import emb_pkg::*;
#(
  parameter int unsigned DEPTH = BUF_DEPTH,
  parameter int unsigned W     = REC_W,
  parameter int unsigned AW    = $clog2(DEPTH),
  parameter int unsigned CW    = $clog2(DEPTH + 1)
)(
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          ce,
  input  wire logic          wr_en,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [4:0]    rd_off,
  output logic      [W-1:0]  rd_data,
  input  wire logic          pop_en,
  input  wire logic [4:0]    pop_n,
  output logic      [CW-1:0] count,
  output logic               full
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] head;
  logic [AW-1:0] tail;
  logic [AW-1:0] next_head;
  logic [AW-1:0] next_tail;
  logic [CW-1:0] next_count;

  assign full    = (count == CW'(DEPTH));
  // Depth is a power of two, so pointers wrap by overflow.
  assign rd_data = mem[head + AW'(rd_off)];

  // Push and pop may share a cycle; count moves by their difference.
  always_comb begin
    next_head  = head;
    next_tail  = tail;
    next_count = count;
    if (wr_en && !full) begin
      next_tail  = tail + 1'b1;
      next_count = next_count + 1'b1;
    end
    if (pop_en) begin
      next_head  = head + AW'(pop_n);
      next_count = next_count - CW'(pop_n);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
    end else if (ce) begin
      head  <= next_head;
      tail  <= next_tail;
      count <= next_count;
    end
  end

  // Storage needs no reset; only entries between head and tail are read.
  always_ff @(posedge clk_sys) begin
    if (ce && wr_en && !full) begin
      mem[tail] <= wr_data;
    end
  end
endmodule : emb_evbuf

// ### rtl/emb_packer.sv
// Top level: buffers events and streams them out as 250-word blocks.
module emb_packer
  import emb_pkg::*;
#(
  parameter int unsigned DEPTH = BUF_DEPTH,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
)(
  // Clock, synchronous reset and the clock enable that freezes all state.
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              pass_thru_en,
  // Event intake; every field is sampled together with ev_valid.
  input  wire logic              ev_valid,
  output logic                   ev_ready,
  input  wire logic [15:0]       session_idx,
  input  wire logic [15:0]       sector_idx,
  input  wire logic [7:0]        cot,
  input  wire logic [7:0]        orig_addr,
  input  wire logic              cot_one_byte,
  input  wire logic [31:0]       point_idx,
  input  wire logic [15:0]       asdu_type,
  input  wire logic [15:0]       ts_ms_sec,
  input  wire logic [15:0]       ts_min_hr,
  input  wire logic [15:0]       ts_mon_day,
  input  wire logic [15:0]       ts_year,
  input  wire logic [15:0]       qualifier,
  input  wire logic [31:0]       point_value,
  // Block stream toward the host; the id fills word 1 of each block.
  input  wire logic [15:0]       next_block_id,
  output logic                   blk_valid,
  input  wire logic              blk_ready,
  output logic      [WORD_W-1:0] blk_data,
  output logic      [POS_W-1:0]  blk_pos,
  output logic                   blk_last,
  // Ordinary-transfer arbitration and buffer status.
  input  wire logic              norm_req,
  output logic                   norm_grant,
  output logic      [CW-1:0]     ev_count,
  output logic                   ev_overflow
);
  // Two states suffice: the position counter carries the rest.
  typedef enum logic [0:0] {
    EMB_IDLE,
    EMB_SEND
  } emb_state_t;

  // Sequencer, header-group and buffer-interface signals.
  emb_state_t        state;
  emb_state_t        next_state;
  logic [POS_W-1:0]  next_blk_pos;
  logic [WORD_W-1:0] next_blk_data;
  logic [4:0]        slot;
  logic [4:0]        next_slot;
  logic [3:0]        rw;
  logic [3:0]        next_rw;
  logic [4:0]        nrec;
  logic [4:0]        next_nrec;
  logic [15:0]       blk_id;
  logic [15:0]       next_blk_id;
  logic              next_ev_overflow;
  logic [REC_W-1:0]  new_rec;
  logic [REC_W-1:0]  rd_rec;
  logic [4:0]        rd_off;
  logic              buf_full;
  logic              push;
  logic              pop;
  logic              pending;
  logic              advance;
  logic              start;

  // True for positions inside the seventeen record slots.
  // Shared by the word lookup and the slot stepping of the sequencer.
  function automatic logic in_slots(
    input logic [POS_W-1:0] pos
  );
    return (pos >= POS_REC_FST) && (pos <= POS_REC_LST);
  endfunction : in_slots

  // Returns the block word at a position, given the record read for it.
  // Slots past the block's count and the spare words read as zero.
  function automatic logic [WORD_W-1:0] word_at(
    input logic [POS_W-1:0] pos,
    input logic [4:0]       s,
    input logic [3:0]       w,
    input logic [4:0]       n,
    input logic [15:0]      id,
    input logic [REC_W-1:0] r
  );
    logic [WORD_W-1:0] v;
    v = 16'h0000;
    if (pos == POS_BLKID) begin
      v = id;
    end else if (pos == POS_COUNT) begin
      v = {11'h000, n};
    end else if (in_slots(pos)) begin
      if (s < n) begin
        v = r[w*WORD_W +: WORD_W];
      end
    end else if (pos == BLK_LAST_POS) begin
      v = BLK_CODE;
    end
    return v;
  endfunction : word_at

  // Record formatting happens on arrival so the buffer holds final words.
  // Formatting is pure logic, so it costs no cycle on the way in.
  emb_recfmt u_recfmt (
    .session_idx  (session_idx),
    .sector_idx   (sector_idx),
    .cot          (cot),
    .orig_addr    (orig_addr),
    .cot_one_byte (cot_one_byte),
    .point_idx    (point_idx),
    .asdu_type    (asdu_type),
    .ts_ms_sec    (ts_ms_sec),
    .ts_min_hr    (ts_min_hr),
    .ts_mon_day   (ts_mon_day),
    .ts_year      (ts_year),
    .qualifier    (qualifier),
    .point_value  (point_value),
    .rec          (new_rec)
  );

  // A whole block's records leave the buffer in one pop after word 249.
  emb_evbuf #(
    .DEPTH (DEPTH),
    .W     (REC_W)
  ) u_evbuf (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .wr_en   (push),
    .wr_data (new_rec),
    .rd_off  (rd_off),
    .rd_data (rd_rec),
    .pop_en  (pop),
    .pop_n   (nrec),
    .count   (ev_count),
    .full    (buf_full)
  );

  // intake gated by enable
  // While disabled, events are taken and dropped so the port never hangs.
  assign ev_ready = pass_thru_en ? !buf_full : 1'b1;
  // append each event
  // Events offered while disabled are swallowed and never stored.
  assign push     = ce && ev_valid && ev_ready && pass_thru_en;

  // pending block wins
  // A disabled packer claims the port only to finish a block already begun, even with records left.
  assign pending    = pass_thru_en && (ev_count != '0);
  assign norm_grant = norm_req && (state == EMB_IDLE) && !pending;

  // Stream handshake: a word moves on an edge with valid, ready and ce.
  assign blk_valid = (state == EMB_SEND);
  assign blk_last  = blk_valid && (blk_pos == BLK_LAST_POS);
  assign advance   = ce && blk_valid && blk_ready;
  // remove sent records
  // Popping on the last word frees the slots before the next start.
  // no acknowledgement wait
  assign pop       = advance && blk_last;

  // Sequencer start: an idle packer takes the pending records at once.
  // Starting only from idle costs one dead cycle between blocks.
  assign start = (state == EMB_IDLE) && pending;

  // Header group: record count and block id are latched once per block.
  // Own registers keep them steady while later events queue behind.
  // The count is cut at seventeen; the rest waits for the next block.
  always_comb begin
    next_nrec   = nrec;
    next_blk_id = blk_id;
    if (start) begin
      next_nrec   = (ev_count > CW'(MAX_REC)) ? MAX_REC
                                              : 5'(ev_count);
      next_blk_id = next_block_id;
    end
  end

  // Header registers; held while the clock enable is low.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      nrec   <= '0;
      blk_id <= '0;
    end else if (ce) begin
      nrec   <= next_nrec;
      blk_id <= next_blk_id;
    end
  end

  // Sequencer: walks the block one word per accepted transfer.
  // The next word is looked up a cycle ahead, so blk_data comes from a
  // flip-flop and a stalled host keeps seeing a steady word.
  always_comb begin
    next_state    = state;
    next_blk_pos  = blk_pos;
    next_slot     = slot;
    next_rw       = rw;
    next_blk_data = blk_data;
    rd_off        = slot;
    case (state)
      EMB_IDLE: begin
        if (start) begin
          // A new block always opens with the reserved word.
          next_blk_pos = POS_RSVD;
          next_slot    = '0;
          next_rw      = '0;
          next_state   = EMB_SEND;
          next_blk_data = 16'h0000;
        end
      end
      EMB_SEND: begin
        if (advance) begin
          if (blk_last) begin
            next_state = EMB_IDLE;
          end else begin
            next_blk_pos = blk_pos + 1'b1;
            if (in_slots(blk_pos)) begin
              if (rw == RW_LAST) begin
                next_rw   = '0;
                next_slot = slot + 1'b1;
              end else begin
                next_rw = rw + 1'b1;
              end
            end
            // Read at the next word's slot (next_slot), matching the word loaded next.
            rd_off        = next_slot;
            next_blk_data = word_at(next_blk_pos, next_slot, next_rw,
                                    nrec, blk_id, rd_rec);
          end
        end
      end
      // An illegal state falls back to idle and waits for a start.
      default: begin
        next_state = EMB_IDLE;
      end
    endcase
  end

  // Registers for the sequencer; all hold while the clock enable is low.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state    <= EMB_IDLE;
      blk_pos  <= '0;
      blk_data <= '0;
      slot     <= '0;
      rw       <= '0;
    end else if (ce) begin
      state    <= next_state;
      blk_pos  <= next_blk_pos;
      blk_data <= next_blk_data;
      slot     <= next_slot;
      rw       <= next_rw;
    end
  end

  // overflow above limit
  // The flag is a level of the count, one cycle late, so it falls by
  // itself once the host has drained the buffer to the limit or below.
  // It is not sticky: a user who must see every burst has to poll it.
  always_comb begin
    next_ev_overflow = (ev_count > CW'(OVF_LIMIT));
  end

  // Overflow register; held while the clock enable is low.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ev_overflow <= 1'b0;
    end else if (ce) begin
      ev_overflow <= next_ev_overflow;
    end
  end
endmodule : emb_packer

// ### rtl/emb_pkg.sv
// Shared constants for the event message block packer.
package emb_pkg;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned POS_W    = 8;
  // Block geometry and fixed word positions.
  localparam logic [7:0]  BLK_LAST_POS = 8'hf9;  // Word 249.
  localparam logic [7:0]  POS_RSVD     = 8'h00;
  localparam logic [7:0]  POS_BLKID    = 8'h01;
  localparam logic [7:0]  POS_COUNT    = 8'h02;
  localparam logic [7:0]  POS_REC_FST  = 8'h03;
  localparam logic [7:0]  POS_REC_LST  = 8'hf0;  // Word 240.
  localparam logic [15:0] BLK_CODE     = 16'h26af; // Decimal 9903.
  // Record layout.
  localparam int unsigned REC_WORDS    = 14;
  localparam logic [3:0]  RW_LAST      = 4'hd;
  localparam int unsigned RW_SESSION   = 0;
  localparam int unsigned RW_SECTOR    = 1;
  localparam int unsigned RW_COT       = 2;
  localparam int unsigned RW_RSVD      = 3;
  localparam int unsigned RW_POINT_LO  = 4;
  localparam int unsigned RW_POINT_HI  = 5;
  localparam int unsigned RW_ASDU      = 6;
  localparam int unsigned RW_MS_SEC    = 7;
  localparam int unsigned RW_MIN_HR    = 8;
  localparam int unsigned RW_MON_DAY   = 9;
  localparam int unsigned RW_YEAR      = 10;
  localparam int unsigned RW_QUAL      = 11;
  localparam int unsigned RW_VALUE_LO  = 12;
  localparam int unsigned RW_VALUE_HI  = 13;
  localparam int unsigned REC_W        = REC_WORDS * WORD_W;
  // Record count limits and buffer defaults.
  localparam logic [4:0]  MAX_REC      = 5'h11;  // 17 records.
  localparam int unsigned OVF_LIMIT    = 200;
  localparam int unsigned BUF_DEPTH    = 256;
endpackage : emb_pkg

// ### rtl/emb_recfmt.sv
// Formats one incoming event into a fourteen-word record.
module emb_recfmt
  import emb_pkg::*;
(
  input  wire logic [15:0]    session_idx,
  input  wire logic [15:0]    sector_idx,
  input  wire logic [7:0]     cot,
  input  wire logic [7:0]     orig_addr,
  input  wire logic           cot_one_byte,
  input  wire logic [31:0]    point_idx,
  input  wire logic [15:0]    asdu_type,
  input  wire logic [15:0]    ts_ms_sec,
  input  wire logic [15:0]    ts_min_hr,
  input  wire logic [15:0]    ts_mon_day,
  input  wire logic [15:0]    ts_year,
  input  wire logic [15:0]    qualifier,
  input  wire logic [31:0]    point_value,
  output logic      [REC_W-1:0] rec
);
  // Each field lands in its fixed word; lower words hold low halves.
  always_comb begin
    rec = '0;
    rec[RW_SESSION*WORD_W +: WORD_W] = session_idx;
    rec[RW_SECTOR*WORD_W +: WORD_W]  = sector_idx;
    rec[RW_COT*WORD_W +: WORD_W] = {cot_one_byte ? 8'h00 : orig_addr, cot};
    rec[RW_RSVD*WORD_W +: WORD_W]     = 16'h0000;
    rec[RW_POINT_LO*WORD_W +: WORD_W] = point_idx[15:0];
    rec[RW_POINT_HI*WORD_W +: WORD_W] = point_idx[31:16];
    rec[RW_ASDU*WORD_W +: WORD_W]     = asdu_type;
    rec[RW_MS_SEC*WORD_W +: WORD_W]   = ts_ms_sec;
    rec[RW_MIN_HR*WORD_W +: WORD_W]   = ts_min_hr;
    rec[RW_MON_DAY*WORD_W +: WORD_W]  = ts_mon_day;
    rec[RW_YEAR*WORD_W +: WORD_W]     = ts_year;
    rec[RW_QUAL*WORD_W +: WORD_W]     = qualifier;
    rec[RW_VALUE_LO*WORD_W +: WORD_W] = point_value[15:0];
    rec[RW_VALUE_HI*WORD_W +: WORD_W] = point_value[31:16];
  end
endmodule : emb_recfmt

// ### verification/emb_host_model.sv
// Host-side model that takes block words and files them per block.
module emb_host_model (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic        blk_valid,
  input  wire logic [15:0] blk_data,
  input  wire logic [7:0]  blk_pos,
  input  wire logic        blk_last,
  output logic             blk_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16][250];
  logic [4:0]  nb;
  // no reply sent
  // In slow mode ready toggles, so every word after a block's first is held across a stall.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      nb        <= 5'h00;
      blk_ready <= 1'b0;
    end else begin
      blk_ready <= slow ? !blk_ready : 1'b1;
      if (blk_valid && blk_ready) begin
        mem[nb[3:0]][blk_pos] <= blk_data;
        if (blk_last) nb <= nb + 5'h01; // Nothing goes back to the packer.
      end
    end
  end
endmodule : emb_host_model

// ### verification/emb_packer_checker.sv
// Concurrent checks on the block packer's ports.
module emb_packer_checker
  import emb_pkg::*;
#(
  parameter int unsigned DEPTH = BUF_DEPTH,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
)(
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic              ce,
  input wire logic              pass_thru_en,
  input wire logic              ev_valid,
  input wire logic              ev_ready,
  input wire logic              norm_req,
  input wire logic              norm_grant,
  input wire logic              blk_valid,
  input wire logic              blk_ready,
  input wire logic [WORD_W-1:0] blk_data,
  input wire logic [POS_W-1:0]  blk_pos,
  input wire logic              blk_last,
  input wire logic [CW-1:0]     ev_count,
  input wire logic              ev_overflow
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Word layout, ordering and buffer bookkeeping seen at the ports.
  a_code_last: assert property (blk_valid && blk_pos == 8'hf9
    |-> blk_last && blk_data == 16'h26af) else $error("bad last word");
  a_word_zero: assert property (blk_valid && blk_pos == 8'h00
    |-> blk_data == 16'h0000) else $error("word 0 not zero");
  a_count_range: assert property (blk_valid && blk_pos == 8'h02
    |-> blk_data inside {[16'h0001:16'h0011]}) else $error("bad count");
  a_spare_zero: assert property (blk_pos inside {[8'hf1:8'hf8]}
    && blk_valid |-> blk_data == 16'h0000) else $error("spare not zero");
  a_word_step: assert property (ce && blk_valid && blk_ready
    && !blk_last |=> blk_valid && blk_pos == $past(blk_pos) + 8'h01)
    else $error("word order broken");
  a_word_hold: assert property (ce && blk_valid && !blk_ready |=>
    blk_valid && $stable(blk_pos) && $stable(blk_data))
    else $error("word not held");
  a_next_block: assert property (ce && blk_last && blk_ready
    && pass_thru_en && ev_count > 17 |=> !blk_valid ##1 blk_valid)
    else $error("next block late");
  a_ovf_level: assert property (ce |=>
    ev_overflow == ($past(ev_count) > 200)) else $error("bad overflow");
  a_grant_idle: assert property (norm_grant |-> norm_req
    && !blk_valid && ev_count == '0) else $error("grant while busy");
  a_start_en: assert property ($rose(blk_valid) |->
    $past(pass_thru_en)) else $error("block while disabled");
  a_count_push: assert property (ce && pass_thru_en && ev_valid
    && ev_ready && !blk_valid |=> ev_count == $past(ev_count) + 1'b1)
    else $error("event not stored");
  c_block_done: cover property (blk_last && blk_ready);
  c_overflow: cover property ($rose(ev_overflow));
  c_stall: cover property (blk_valid && !blk_ready);
endmodule : emb_packer_checker

bind emb_packer emb_packer_checker #(.DEPTH(DEPTH), .CW(CW)) chk_i (
  .clk_sys, .resetn, .ce, .pass_thru_en, .ev_valid, .ev_ready, .norm_req,
  .norm_grant, .blk_valid, .blk_ready, .blk_data, .blk_pos, .blk_last,
  .ev_count, .ev_overflow
);

// ### verification/tb_top.sv
// Self-checking bench for the event block packer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1, slow = 1'b1;
  logic        pass_thru_en = 1'b0, ev_valid = 1'b0, norm_req = 1'b1;
  logic        cot_one_byte, ev_ready, blk_valid, blk_ready, blk_last;
  logic        norm_grant, ev_overflow;
  logic [7:0]  cot, orig_addr, blk_pos;
  logic [15:0] session_idx, sector_idx, asdu_type, ts_ms_sec, ts_min_hr;
  logic [15:0] ts_mon_day, ts_year, qualifier, blk_data;
  logic [15:0] next_block_id = 16'h00c5;
  logic [31:0] point_idx, point_value;
  logic [8:0]  ev_count;
  int          n_fail = 0, samples_checked = 0, cyc = 0, i, b, p;
  // Each row: block number (index) beside its expected record count.
  logic [15:0] row_nrec [14] = '{0: 16'h1, 13: 16'h1, default: 16'h11};

  emb_packer #(.DEPTH(256)) uut (.clk_sys, .resetn, .ce, .pass_thru_en,
    .ev_valid, .ev_ready, .session_idx, .sector_idx, .cot, .orig_addr,
    .cot_one_byte, .point_idx, .asdu_type, .ts_ms_sec, .ts_min_hr,
    .ts_mon_day, .ts_year, .qualifier, .point_value, .next_block_id,
    .blk_valid, .blk_ready, .blk_data, .blk_pos, .blk_last, .norm_req,
    .norm_grant, .ev_count, .ev_overflow);
  emb_host_model host (.clk_sys, .resetn, .slow, .blk_valid, .blk_data,
    .blk_pos, .blk_last, .blk_ready);

  // Field word k of event e; the high byte keeps events apart.
  function automatic logic [15:0] fv(input int e, input int k);
    return {8'(e + 17), 4'hc, 4'(k)};
  endfunction : fv

  // Expected record word at block position p (3..248).
  function automatic logic [15:0] exp_w(input int b, input int p);
    int s, e, k;
    s = (p - 3) / 14;
    k = (p - 3) % 14;
    e = (b == 0) ? 0 : 1 + (b - 1) * 17 + s;
    if (p > 240 || s >= row_nrec[b] || k == 3) return 16'h0000;
    if (k == 2 && e[0]) return fv(e, 2) & 16'h00ff;
    return fv(e, k);
  endfunction : exp_w

  task automatic set_ev(input int e);
    session_idx <= fv(e, 0);
    sector_idx <= fv(e, 1);
    {orig_addr, cot} <= fv(e, 2);
    cot_one_byte <= e[0];
    point_idx <= {fv(e, 5), fv(e, 4)};
    asdu_type <= fv(e, 6);
    ts_ms_sec <= fv(e, 7);
    ts_min_hr <= fv(e, 8);
    ts_mon_day <= fv(e, 9);
    ts_year <= fv(e, 10);
    qualifier <= fv(e, 11);
    point_value <= {fv(e, 13), fv(e, 12)};
  endtask : set_ev

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  always #5 clk_sys = ~clk_sys;

  // Drain of 14 blocks takes about 4000 cycles; the ceiling leaves margin.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    set_ev(0);
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk(16'(ev_count), 16'h0000);
    chk(16'({blk_valid, ev_overflow, ev_ready}), 16'h1);
    @(posedge clk_sys) ev_valid <= 1'b1;
    @(posedge clk_sys) ev_valid <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(16'({blk_valid, ev_count}), 16'h0000);
    // A slow host keeps block 0 busy while all events arrive back to back.
    for (i = 0; i < 206; i++) begin
      @(posedge clk_sys);
      set_ev(i);
      ev_valid <= 1'b1;
      pass_thru_en <= 1'b1;
    end
    @(posedge clk_sys) ev_valid <= 1'b0;
    @(negedge clk_sys);
    chk(16'(ev_count), 16'd206);
    chk(16'(norm_grant), 16'h0000);
    @(negedge clk_sys);
    chk(16'(ev_overflow), 16'h0001);
    // Clock enable low freezes the block mid-stream and the buffer.
    @(posedge clk_sys) ce <= 1'b0;
    @(negedge clk_sys);
    p = blk_pos;
    b = blk_data;
    repeat (4) @(negedge clk_sys);
    chk(16'(blk_pos), 16'(p));
    chk(blk_data, 16'(b));
    chk(16'(ev_count), 16'd206);
    @(posedge clk_sys) ce <= 1'b1;
    @(posedge clk_sys) slow <= 1'b0;
    for (i = 0; i < 8000 && host.nb != 14; i++) @(posedge clk_sys);
    repeat (3) @(negedge clk_sys);
    chk(16'(host.nb), 16'd14);
    chk(16'({ev_count, ev_overflow, norm_grant}), 16'h1);
    for (b = 0; b < 14; b++) begin
      chk(host.mem[b][0], 16'h0000);
      chk(host.mem[b][1], 16'h00c5);
      chk(host.mem[b][2], row_nrec[b]);
      chk(host.mem[b][249], 16'h26af);
      for (p = 3; p < 249; p++) chk(host.mem[b][p], exp_w(b, p));
    end
    chk(host.mem[1][3], 16'h12c0);
    chk(host.mem[1][5], 16'h00c2);
    chk(host.mem[1][19], 16'h13c2);
    chk(host.mem[1][6], 16'h0000);
    chk(host.mem[1][7], 16'h12c4);
    chk(host.mem[1][10], 16'h12c7);
    chk(host.mem[1][14], 16'h12cb);
    chk(host.mem[13][17], 16'h0000);
    results();
  end
endmodule : tb_top
